// file: src/dma_ctrl_frame_regs.svh
/*
  Constants of the DMA control frame transmitter: frame type codes,
  frame lengths in words and field positions of the first word.
  Assumes inclusion by the design modules, the link model and the bench.
*/
`ifndef DMA_CTRL_FRAME_REGS_SVH
`define DMA_CTRL_FRAME_REGS_SVH

// Frame type codes, first byte of word zero
`define ACT_FRAME_TYPE     8'h39
`define SETUP_FRAME_TYPE   8'h41

// Frame lengths in 32-bit words
`define ACT_FRAME_WORDS    3'h1
`define SETUP_FRAME_WORDS  3'h7

// Word zero field positions
`define TYPE_LSB           0
`define CTRL_LSB           8
`define DIR_BIT            13
`define IRQ_BIT            14

// Setup frame word indices
`define BUF_ID_LO_WORD     3'h1
`define BUF_ID_HI_WORD     3'h2
`define BUF_OFFSET_WORD    3'h4
`define BYTE_COUNT_WORD    3'h5

// Reset values
`define WORD_RESET         32'h0000_0000
`define IDX_RESET          3'h0

`endif

// file: src/dma_ctrl_frame_pkg.sv
/*
  Types of the DMA control frame transmitter: states, frame kinds,
  frame content and link-side carriers.
  Uses literal codes, not the constants of dma_ctrl_frame_regs.svh.
*/
package dma_ctrl_frame_pkg;

  typedef enum logic [3:0] {
    transport_idle_state         = 4'h1,
    activate_build_state         = 4'h2,
    setup_build_state            = 4'h4,
    transmit_status_check_state  = 4'h8
  } xmit_state_e;

  typedef enum logic {
    kind_activate = 1'b0,
    kind_setup    = 1'b1
  } frame_kind_e;

  typedef struct packed {
    logic        to_host;
    logic [63:0] buf_id;
    logic [31:0] buf_offset;
    logic [31:0] byte_count;
    logic        irq;
  } setup_content_s;

  typedef struct packed {
    logic        pending;
    logic        valid;
    logic [31:0] word;
    logic        last;
  } link_tx_s;

  typedef struct packed {
    logic ok;
    logic err;
  } link_status_s;

endpackage

// file: src/frame_word_build.sv
/*
  Picks one word of a DMA control frame from the latched content.
  Assumes the caller steps the word index from zero to length - 1.
*/
`timescale 1ns/10ps
`include "dma_ctrl_frame_regs.svh"

module frame_word_build (
  input  wire dma_ctrl_frame_pkg::frame_kind_e    kind,
  input  wire logic [2:0]                         idx,
  input  wire logic [7:0]                         act_ctrl,
  input  wire dma_ctrl_frame_pkg::setup_content_s setup,
  output logic [31:0]                             word
);

  always_comb begin
    word = `WORD_RESET;
    if (kind == dma_ctrl_frame_pkg::kind_activate) begin
      word[`TYPE_LSB +: 8] = `ACT_FRAME_TYPE;
      word[`CTRL_LSB +: 8] = act_ctrl;
    end else begin
      // Five content items of the setup frame
      case (idx)
        3'h0: begin
          word[`TYPE_LSB +: 8] = `SETUP_FRAME_TYPE;
          word[`DIR_BIT]       = setup.to_host;
          word[`IRQ_BIT]       = setup.irq;
        end
        `BUF_ID_LO_WORD:  word = setup.buf_id[31:0];
        `BUF_ID_HI_WORD:  word = setup.buf_id[63:32];
        `BUF_OFFSET_WORD: word = setup.buf_offset;
        `BYTE_COUNT_WORD: word = setup.byte_count;
        default:          word = `WORD_RESET;
      endcase
    end
  end

endmodule // frame_word_build

// file: src/dma_control_frame_transmit.sv
/*
  Device transport transmitter for the legacy DMA activate frame and the
  first-party DMA setup frame, device to host.
  Assumes the link layer takes one word per cycle without stalling and
  that every input comes from logic on sys_clk.
*/
//
// Overview of operation
// - An activate request moves to the activate build state, which builds the frame, flags it pending and hands it over.
// - The activate frame goes to the link one word per cycle with no throttling.
// - After the last word of either frame the link is told the frame is complete and the status check state follows.
// - An illegal transition reported by the link during build drops the frame and returns to idle.
// - The status check state waits for the link ending status and acts on a failure.
// - A good ending status returns the block to idle.
// - A failed ending status is reported to the link and the same frame kind is built and sent again.
// - A setup request without an activate request in the same cycle moves to the setup build state, which builds the frame, flags it pending and hands it over.
// - The setup frame carries direction, buffer identifier, buffer offset, byte count and interrupt flag.
// - The setup frame goes to the link one word per cycle with no throttling.
// - One or more data frames follow a setup frame in the direction it names.
`timescale 1ns/10ps
`include "dma_ctrl_frame_regs.svh"

module dma_control_frame_transmit (
  input  wire logic                               sys_clk,
  input  wire logic                               rst,
  // Application side
  input  wire logic                               act_req,
  input  wire logic [7:0]                         act_ctrl,
  input  wire logic                               setup_req,
  input  wire dma_ctrl_frame_pkg::setup_content_s setup_content,
  output logic                                    busy,
  output logic                                    frame_done,
  output logic                                    frame_dropped,
  output logic                                    data_to_host,
  // Link side
  output dma_ctrl_frame_pkg::link_tx_s            link_tx,
  input  wire logic                               link_illegal,
  input  wire dma_ctrl_frame_pkg::link_status_s   link_status,
  output logic                                    link_err_report
);

  typedef struct packed {
    dma_ctrl_frame_pkg::xmit_state_e    state;
    dma_ctrl_frame_pkg::frame_kind_e    kind;
    logic [2:0]                         idx;
    logic [7:0]                         act_ctrl;
    dma_ctrl_frame_pkg::setup_content_s setup;
    dma_ctrl_frame_pkg::link_tx_s       tx;
    logic                               busy;
    logic                               done;
    logic                               dropped;
    logic                               err_report;
    logic                               to_host;
  } ctl_s;

  localparam ctl_s CTL_RESET = '{
    state:      dma_ctrl_frame_pkg::transport_idle_state,
    kind:       dma_ctrl_frame_pkg::kind_activate,
    idx:        `IDX_RESET,
    act_ctrl:   8'h00,
    setup:      '0,
    tx:         '0,
    busy:       1'b0,
    done:       1'b0,
    dropped:    1'b0,
    err_report: 1'b0,
    to_host:    1'b0
  };

  ctl_s        s_r;
  ctl_s        s_nxt;
  logic [31:0] cur_word;

  // Last word index of a frame kind
  function automatic logic [2:0] last_idx(
    input dma_ctrl_frame_pkg::frame_kind_e k
  );
    logic [2:0] len;
    len = (k == dma_ctrl_frame_pkg::kind_activate) ?
          `ACT_FRAME_WORDS : `SETUP_FRAME_WORDS;
    return len - 3'h1;
  endfunction

  // Build state of a frame kind
  function automatic dma_ctrl_frame_pkg::xmit_state_e build_state(
    input dma_ctrl_frame_pkg::frame_kind_e k
  );
    return (k == dma_ctrl_frame_pkg::kind_activate) ?
           dma_ctrl_frame_pkg::activate_build_state :
           dma_ctrl_frame_pkg::setup_build_state;
  endfunction

  frame_word_build u_word (
    .kind     (s_r.kind),
    .idx      (s_r.idx),
    .act_ctrl (s_r.act_ctrl),
    .setup    (s_r.setup),
    .word     (cur_word)
  );

  always_comb begin
    s_nxt            = s_r;
    s_nxt.done       = 1'b0;
    s_nxt.dropped    = 1'b0;
    s_nxt.err_report = 1'b0;
    s_nxt.tx.valid   = 1'b0;
    s_nxt.tx.last    = 1'b0;
    s_nxt.tx.word    = `WORD_RESET;
    case (s_r.state)
      dma_ctrl_frame_pkg::transport_idle_state: begin
        s_nxt.tx.pending = 1'b0;
        s_nxt.busy       = 1'b0;
        s_nxt.idx        = `IDX_RESET;
        if (act_req) begin
          s_nxt.kind     = dma_ctrl_frame_pkg::kind_activate;
          s_nxt.act_ctrl = act_ctrl;
          s_nxt.state    = dma_ctrl_frame_pkg::activate_build_state;
          s_nxt.busy     = 1'b1;
        end else if (setup_req) begin
          s_nxt.kind     = dma_ctrl_frame_pkg::kind_setup;
          s_nxt.setup    = setup_content;
          s_nxt.to_host  = setup_content.to_host;
          s_nxt.state    = dma_ctrl_frame_pkg::setup_build_state;
          s_nxt.busy     = 1'b1;
        end
      end
      dma_ctrl_frame_pkg::activate_build_state,
      dma_ctrl_frame_pkg::setup_build_state: begin
        if (link_illegal) begin
          s_nxt.state      = dma_ctrl_frame_pkg::transport_idle_state;
          s_nxt.tx.pending = 1'b0;
          s_nxt.busy       = 1'b0;
          s_nxt.dropped    = 1'b1;
          s_nxt.idx        = `IDX_RESET;
        end else begin
          // One word per cycle, link never stalls
          s_nxt.tx.pending = 1'b1;
          s_nxt.tx.valid   = 1'b1;
          s_nxt.tx.word    = cur_word;
          if (s_r.idx == last_idx(s_r.kind)) begin
            s_nxt.tx.last = 1'b1;
            s_nxt.idx     = `IDX_RESET;
            s_nxt.state   = dma_ctrl_frame_pkg::transmit_status_check_state;
          end else begin
            s_nxt.idx = s_r.idx + 3'h1;
          end
        end
      end
      dma_ctrl_frame_pkg::transmit_status_check_state: begin
        s_nxt.tx.pending = 1'b0;
        if (link_status.err) begin
          s_nxt.err_report = 1'b1;
          s_nxt.state      = build_state(s_r.kind);
        end else if (link_status.ok) begin
          s_nxt.done  = 1'b1;
          s_nxt.busy  = 1'b0;
          s_nxt.state = dma_ctrl_frame_pkg::transport_idle_state;
        end
      end
      default: begin
        s_nxt = CTL_RESET;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_r <= CTL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy            = s_r.busy;
  assign frame_done      = s_r.done;
  assign frame_dropped   = s_r.dropped;
  assign data_to_host    = s_r.to_host;
  assign link_tx         = s_r.tx;
  assign link_err_report = s_r.err_report;

endmodule // dma_control_frame_transmit

// file: test/dma_frame_monitor.sv
/*
  Port checker for the DMA control frame transmitter.
  Assumes the bind below onto the transmitter top module.
*/
`timescale 1ns/10ps
module dma_frame_monitor (
  input wire logic                             sys_clk,
  input wire logic                             rst,
  input wire logic                             act_req,
  input wire logic [7:0]                       act_ctrl,
  input wire logic                             setup_req,
  input wire logic                             busy,
  input wire logic                             frame_done,
  input wire logic                             frame_dropped,
  input wire dma_ctrl_frame_pkg::link_tx_s     link_tx,
  input wire logic                             link_illegal,
  input wire dma_ctrl_frame_pkg::link_status_s link_status,
  input wire logic                             link_err_report
);
  logic chk_r;
  // Set while the ending status is awaited
  always_ff @(posedge sys_clk or posedge rst)
    if (rst) chk_r <= 1'b0;
    else if (link_tx.last) chk_r <= 1'b1;
    else if (link_status.ok || link_status.err) chk_r <= 1'b0;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  req_taken_a: assert property ((act_req || setup_req) && !busy |=> busy)
    else $error("request not taken");
  act_word_a: assert property (act_req && !busy |-> ##2 link_tx.valid &&
    link_tx.last && link_tx.word[15:0] == {$past(act_ctrl, 2), 8'h39})
    else $error("activate word wrong");
  no_throttle_a: assert property (link_tx.valid && !link_tx.last &&
    !link_illegal |=> link_tx.valid) else $error("word stream gap");
  pend_valid_a: assert property (link_tx.valid |-> link_tx.pending)
    else $error("word without pending");
  last_end_a: assert property (link_tx.last |=> !link_tx.valid[*2])
    else $error("words after last");
  illegal_drop_a: assert property (link_tx.valid && !link_tx.last &&
    link_illegal |-> ##[1:2] frame_dropped) else $error("no drop");
  good_done_a: assert property (chk_r && link_status.ok &&
    !link_status.err |=> frame_done && !busy) else $error("no done");
  err_retry_a: assert property (chk_r && link_status.err |=>
    link_err_report ##1 link_tx.valid) else $error("no retry");
  done_cause_a: assert property (frame_done |-> $past(link_status.ok))
    else $error("done without status");
  done_c: cover property (frame_done);
  retry_c: cover property (link_err_report);
  drop_c: cover property (frame_dropped);
endmodule // dma_frame_monitor

bind dma_control_frame_transmit dma_frame_monitor u_mon (.sys_clk, .rst,
  .act_req, .act_ctrl, .setup_req, .busy, .frame_done, .frame_dropped,
  .link_tx, .link_illegal, .link_status, .link_err_report);

// file: test/link_model.sv
/*
  Link layer model: takes words, answers ending status, can flag
  an illegal transition at a chosen word.
  Assumes the bench sets delay, drop word and error target.
*/
`timescale 1ns/10ps
`include "dma_ctrl_frame_regs.svh"
module link_model (
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  input  wire dma_ctrl_frame_pkg::link_tx_s link_tx,
  input  var  int                           dly,
  input  var  int                           drop_at,
  input  var  int                           err_until,
  output logic                              link_illegal,
  output dma_ctrl_frame_pkg::link_status_s  link_status,
  output int                                n_stat,
  output int                                n_data,
  output logic [31:0]                       dma_bytes
);
  int                               cnt;
  int                               wcnt;
  logic [31:0]                      fw[7];
  dma_ctrl_frame_pkg::link_status_s st;
  always @(negedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt = 0;
      wcnt = 0;
      n_stat = 0;
      n_data = 0;
      dma_bytes = '0;
      link_illegal = 1'b0;
      link_status = '0;
    end else begin
      link_illegal = link_tx.valid && !link_tx.last && wcnt == drop_at;
      if (link_tx.valid && wcnt < 7) fw[wcnt] = link_tx.word;
      wcnt = link_tx.valid ? wcnt + 1 : 0;
      st = '0;
      if (link_tx.last) cnt = dly + 1;
      else if (cnt > 0) begin
        cnt--;
        if (cnt == 0) begin
          st.err = n_stat < err_until;
          st.ok = !st.err;
          n_stat++;
          // Host side of a good frame
          if (st.ok && fw[0][7:0] == `ACT_FRAME_TYPE) n_data++;
          if (st.ok && fw[0][7:0] == `SETUP_FRAME_TYPE)
            dma_bytes = fw[`BYTE_COUNT_WORD];
        end
      end
      link_status = st;
    end
  end
endmodule // link_model

// file: test/tb.sv
/*
  Self-checking bench for the DMA control frame transmitter.
  Assumes the link model as far side and the port checker bound in.
*/
`timescale 1ns/10ps
`include "dma_ctrl_frame_regs.svh"
module tb;
  logic sys_clk = 1'b0, rst = 1'b1, act_req = 1'b0, setup_req = 1'b0;
  logic [7:0] act_ctrl = 8'h00;
  logic busy, frame_done, frame_dropped, data_to_host, link_illegal;
  logic link_err_report;
  dma_ctrl_frame_pkg::setup_content_s setup_content = '0;
  dma_ctrl_frame_pkg::link_tx_s       link_tx;
  dma_ctrl_frame_pkg::link_status_s   link_status;
  int dly = 0, drop_at = -1, err_until = 0, n_stat;
  int mismatches = 0, compares = 0, n_data, n_act = 0;
  logic [31:0] dma_bytes;
  logic [32:0] w_q[$];
  logic [2:0]  e_q[$];
  logic [32:0] exp_w;
  logic [2:0]  exp_e;
  always #4 sys_clk = ~sys_clk;
  dma_control_frame_transmit u_dut (.sys_clk, .rst, .act_req, .act_ctrl,
    .setup_req, .setup_content, .busy, .frame_done, .frame_dropped,
    .data_to_host, .link_tx, .link_illegal, .link_status, .link_err_report);
  link_model u_link (.sys_clk, .rst, .link_tx, .dly, .drop_at, .err_until,
    .link_illegal, .link_status, .n_stat, .n_data, .dma_bytes);
  task automatic tally(bit bad, logic [32:0] got, logic [32:0] exp);
    compares++;
    if (bad) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_word(logic [32:0] got, logic [32:0] exp);
    tally(got !== exp, got, exp);
  endtask
  task automatic check_event(logic [2:0] got, logic [2:0] exp);
    tally(got !== exp, {30'h0, got}, {30'h0, exp});
  endtask
  task automatic check_val(logic [31:0] got, logic [31:0] exp);
    tally(got !== exp, {1'b0, got}, {1'b0, exp});
  endtask
  always @(posedge sys_clk) begin
    if (!rst && link_tx.valid) begin
      exp_w = w_q.size() ? w_q.pop_front() : 'x;
      check_word({link_tx.last, link_tx.word}, exp_w);
    end
    if (!rst && (frame_done | frame_dropped | link_err_report)) begin
      exp_e = e_q.size() ? e_q.pop_front() : 'x;
      check_event({link_err_report, frame_dropped, frame_done}, exp_e);
    end
  end
  task automatic run(bit act, int errs, int dr);
    logic [31:0] w[7];
    int n;
    int k;
    w = '{default: 32'h0};
    act_ctrl = 8'($urandom);
    setup_content = 130'({$urandom, $urandom, $urandom, $urandom, $urandom});
    n = act ? 1 : 7;
    w[0] = act ? {16'h0, act_ctrl, `ACT_FRAME_TYPE} : {17'h0, setup_content.irq,
      setup_content.to_host, 5'h0, `SETUP_FRAME_TYPE};
    if (!act) begin
      w[1] = setup_content.buf_id[31:0];
      w[2] = setup_content.buf_id[63:32];
      w[4] = setup_content.buf_offset;
      w[5] = setup_content.byte_count;
    end
    err_until = n_stat + errs;
    drop_at = dr;
    for (int r = 0; r <= errs; r++) begin
      for (int i = 0; i < n; i++)
        if (dr < 0 || i <= dr) w_q.push_back({i == n - 1, w[i]});
      e_q.push_back(dr >= 0 ? 3'h2 : (r < errs ? 3'h4 : 3'h1));
    end
    @(negedge sys_clk);
    act_req = act;
    setup_req = 1'b1;
    @(negedge sys_clk);
    act_req = 1'b0;
    check_val({31'h0, busy}, 32'h1);
    k = 0;
    while (busy && k < 300) begin
      @(negedge sys_clk);
      k++;
      setup_req = k < 2;
    end
    repeat (2) @(negedge sys_clk);
    check_val({31'h0, busy}, 32'h0);
    if (!act) begin
      check_val(32'(data_to_host), 32'(setup_content.to_host));
      if (dr < 0) check_val(dma_bytes, setup_content.byte_count);
    end else if (dr < 0) begin
      n_act++;
      check_val(n_data, n_act);
    end
    check_val(32'(w_q.size() + e_q.size()), 32'h0);
    $display("test end act=%0d errs=%0d drop=%0d", act, errs, dr);
  endtask
  task automatic final_report;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    final_report;
  end
  initial begin
    void'($urandom(49));
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    for (int i = 0; i < 6; i++) begin
      dly = i;
      run(i[0], i / 2, -1);
    end
    dly = 2;
    run(0, 0, 0);
    run(0, 0, 3);
    run(0, 0, 5);
    run(1, 0, -1);
    final_report;
  end
endmodule // tb
